// File: aso_alu.sv
// Purpose: shared constants, opcode decode and the 8-bit arithmetic unit
// Assumes: single clock domain, operands are stable for the whole cycle
// Notes:   the unit is purely combinational; the core registers its results
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// constants and decode
// ****************************************
package aso_pkg;

    // register map, byte addresses on the apb bus
    localparam int          ASO_AW          = 12;
    localparam logic [11:0] ASO_ADDR_INSTR  = 12'h000;
    localparam logic [11:0] ASO_ADDR_ACC    = 12'h004;
    localparam logic [11:0] ASO_ADDR_FLAGS  = 12'h008;
    localparam logic [11:0] ASO_ADDR_PTR0   = 12'h00c;
    localparam logic [11:0] ASO_ADDR_PTR1   = 12'h010;
    localparam logic [11:0] ASO_ADDR_DATA_LO = 12'h200;
    localparam logic [11:0] ASO_ADDR_DATA_HI = 12'h3fc;

    // flag register layout
    localparam int          ASO_FLG_C       = 0;
    localparam int          ASO_FLG_HC      = 1;
    localparam int          ASO_FLG_Z       = 2;

    // instruction word fields
    localparam int          ASO_DEST_BIT    = 7;
    localparam int          ASO_SEL_BIT     = 6;
    localparam int          ASO_DEPTH       = 128;

    // reset values
    localparam logic [7:0]  ASO_RST_ACC     = 8'h00;
    localparam logic [2:0]  ASO_RST_FLAGS   = 3'h0;
    localparam logic [15:0] ASO_RST_PTR     = 16'h0000;
    localparam logic [7:0]  ASO_RST_DATA    = 8'h00;
    localparam logic [13:0] ASO_RST_INSTR   = 14'h0000;

    // opcodes, word bits 13:8 (pointer add uses bits 13:7)
    localparam logic [5:0]  ASO_OPC_ADD_IMM = 6'h3e;
    localparam logic [5:0]  ASO_OPC_AND_IMM = 6'h39;
    localparam logic [5:0]  ASO_OPC_AND_REG = 6'h05;
    localparam logic [5:0]  ASO_OPC_ADD_REG = 6'h07;
    localparam logic [5:0]  ASO_OPC_ADC_REG = 6'h3d;
    localparam logic [5:0]  ASO_OPC_ASR_REG = 6'h37;
    localparam logic [6:0]  ASO_OPC_PTR_ADD = 7'h62;

    typedef enum logic [2:0] {
        ASO_OP_NONE,
        ASO_OP_ADD,
        ASO_OP_ADC,
        ASO_OP_AND,
        ASO_OP_ASR,
        ASO_OP_PTR
    } aso_op_e;

    function automatic aso_op_e aso_decode(input logic [13:0] w);
        aso_op_e r;
        r = ASO_OP_NONE;
        if (w[13:7] == ASO_OPC_PTR_ADD) begin
            r = ASO_OP_PTR;
        end else begin
            case (w[13:8])
                ASO_OPC_ADD_IMM, ASO_OPC_ADD_REG: r = ASO_OP_ADD;
                ASO_OPC_ADC_REG:                  r = ASO_OP_ADC;
                ASO_OPC_AND_IMM, ASO_OPC_AND_REG: r = ASO_OP_AND;
                ASO_OPC_ASR_REG:                  r = ASO_OP_ASR;
                default:                          r = ASO_OP_NONE;
            endcase
        end
        return r;
    endfunction

    function automatic logic aso_is_imm(input logic [13:0] w);
        return (w[13:8] == ASO_OPC_ADD_IMM) || (w[13:8] == ASO_OPC_AND_IMM);
    endfunction

endpackage

// ****************************************
// arithmetic unit
// ****************************************
module aso_alu (
    // operation
    input  wire aso_pkg::aso_op_e op,
    // operands
    input  wire logic [7:0]       a_in,
    input  wire logic [7:0]       b_in,
    input  wire logic             carry_in,
    // results
    output logic [7:0]            result,
    output logic                  carry_out,
    output logic                  half_out,
    output logic                  zero_out
);
    import aso_pkg::*;

    logic [8:0] sum;
    logic [4:0] half;
    logic       cin;

    // carry in only for the add-with-carry form
    assign cin  = (op == ASO_OP_ADC) ? carry_in : 1'b0;
    assign sum  = {1'b0, a_in} + {1'b0, b_in} + {8'h00, cin};
    assign half = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, cin};

    always_comb begin
        result    = sum[7:0];
        carry_out = sum[8];
        case (op)
            ASO_OP_AND: begin
                result = a_in & b_in;
            end
            ASO_OP_ASR: begin
                result    = {b_in[7], b_in[7:1]};
                carry_out = b_in[0];
            end
            default: begin
                result = sum[7:0];
            end
        endcase
    end

    assign half_out = half[4];
    assign zero_out = (result == 8'h00);

endmodule // aso_alu

`default_nettype wire

// File: aso_core.sv
// Purpose: add/and/shift execution datapath with apb register access
// Assumes: one apb transfer at a time, a write to the instruction word
//          register is one instruction cycle
// Notes:   pready is always high, so every transfer ends in its first
//          access cycle
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module aso_core (
    // clock and reset
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // apb slave
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [aso_pkg::ASO_AW-1:0] paddr,
    input  wire logic [31:0]              pwdata,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr
);
    import aso_pkg::*;

    // ****************************************
    // state
    // ****************************************
    logic [7:0]  acc_r;
    logic [2:0]  flags_r;
    logic [15:0] ptr_r [2];
    logic [7:0]  dfile_r [ASO_DEPTH];
    logic [13:0] instr_r;
    logic [31:0] prdata_r;

    // ****************************************
    // bus decode
    // ****************************************
    logic        access;
    logic        wr;
    logic        in_data;
    logic        addr_ok;
    logic [6:0]  didx;
    logic        instr_hit;

    assign access    = psel & penable;
    assign wr        = access & pwrite;
    assign in_data   = (paddr >= ASO_ADDR_DATA_LO) && (paddr <= ASO_ADDR_DATA_HI)
                       && (paddr[1:0] == 2'b00);
    assign didx      = paddr[8:2];
    assign addr_ok   = in_data || (paddr == ASO_ADDR_INSTR) || (paddr == ASO_ADDR_ACC)
                       || (paddr == ASO_ADDR_FLAGS) || (paddr == ASO_ADDR_PTR0)
                       || (paddr == ASO_ADDR_PTR1);
    assign instr_hit = wr & (paddr == ASO_ADDR_INSTR);

    // ****************************************
    // instruction decode
    // ****************************************
    logic [13:0] iw;
    aso_op_e     op;
    logic        imm;
    logic [6:0]  fidx;
    logic        dest_reg;
    logic [7:0]  operand;
    logic        exec;
    logic        exec_alu;
    logic        exec_ptr;
    logic        ptr_sel;
    logic [15:0] ptr_lit;
    logic [15:0] ptr_sum;

    assign iw       = pwdata[13:0];
    assign op       = aso_decode(iw);
    assign imm      = aso_is_imm(iw);
    assign fidx     = iw[6:0];
    // literal forms have no destination bit, they always land in the accumulator
    assign dest_reg = iw[ASO_DEST_BIT] & ~imm;
    assign operand  = imm ? iw[7:0] : dfile_r[fidx];
    assign exec     = instr_hit & (op != ASO_OP_NONE);
    assign exec_ptr = exec & (op == ASO_OP_PTR);
    assign exec_alu = exec & (op != ASO_OP_PTR);
    assign ptr_sel  = iw[ASO_SEL_BIT];
    assign ptr_lit  = {{10{iw[5]}}, iw[5:0]};
    // plain 16-bit add drops the carry, giving wrap-around both ways
    assign ptr_sum  = ptr_r[ptr_sel] + ptr_lit;

    // ****************************************
    // arithmetic unit
    // ****************************************
    logic [7:0] alu_res;
    logic       alu_c;
    logic       alu_hc;
    logic       alu_z;

    aso_alu u_alu (
        .op        (op),
        .a_in      (acc_r),
        .b_in      (operand),
        .carry_in  (flags_r[ASO_FLG_C]),
        .result    (alu_res),
        .carry_out (alu_c),
        .half_out  (alu_hc),
        .zero_out  (alu_z)
    );

    // ****************************************
    // accumulator
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_r <= ASO_RST_ACC;
        end else if (exec_alu && !dest_reg) begin
            acc_r <= alu_res;
        end else if (wr && paddr == ASO_ADDR_ACC) begin
            acc_r <= pwdata[7:0];
        end
    end

    // ****************************************
    // status flags
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_r <= ASO_RST_FLAGS;
        end else if (exec_alu) begin
            flags_r[ASO_FLG_Z] <= alu_z;
            unique case (op)
                ASO_OP_ADD, ASO_OP_ADC: begin
                    flags_r[ASO_FLG_C]  <= alu_c;
                    flags_r[ASO_FLG_HC] <= alu_hc;
                end
                ASO_OP_ASR: begin
                    flags_r[ASO_FLG_C]  <= alu_c;
                end
                ASO_OP_AND: begin
                    flags_r[ASO_FLG_C]  <= flags_r[ASO_FLG_C];
                end
            endcase
        end else if (wr && paddr == ASO_ADDR_FLAGS) begin
            flags_r <= pwdata[2:0];
        end
    end

    // ****************************************
    // indirect pointer pairs
    // ****************************************
    for (genvar g = 0; g < 2; g++) begin : g_ptr
        localparam logic [11:0] PADDR = ASO_ADDR_PTR0 + 12'(4 * g);
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ptr_r[g] <= ASO_RST_PTR;
            end else if (exec_ptr && ptr_sel == 1'(g)) begin
                ptr_r[g] <= ptr_sum;
            end else if (wr && paddr == PADDR) begin
                ptr_r[g] <= pwdata[15:0];
            end
        end
    end

    // ****************************************
    // data register file
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < ASO_DEPTH; i++) begin
                dfile_r[i] <= ASO_RST_DATA;
            end
        end else if (exec_alu && dest_reg) begin
            dfile_r[fidx] <= alu_res;
        end else if (wr && in_data) begin
            dfile_r[didx] <= pwdata[7:0];
        end
    end

    // last executed word, for software readback
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_r <= ASO_RST_INSTR;
        end else if (exec) begin
            instr_r <= iw;
        end
    end

    // ****************************************
    // read path
    // ****************************************
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (in_data) begin
            rd_mux[7:0] = dfile_r[didx];
        end else begin
            case (paddr)
                ASO_ADDR_INSTR: rd_mux[13:0] = instr_r;
                ASO_ADDR_ACC:   rd_mux[7:0]  = acc_r;
                ASO_ADDR_FLAGS: rd_mux[2:0]  = flags_r;
                ASO_ADDR_PTR0:  rd_mux[15:0] = ptr_r[0];
                ASO_ADDR_PTR1:  rd_mux[15:0] = ptr_r[1];
                default:        rd_mux       = 32'h0000_0000;
            endcase
        end
    end

    // captured in the setup cycle so read data leaves a flip-flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_r <= rd_mux;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = 1'b1;
    // unknown opcodes are refused rather than silently dropped
    assign pslverr = access & (!addr_ok | (instr_hit & (op == ASO_OP_NONE)));

    // ****************************************
    // reference sums for the checks
    // ****************************************
    // independent adders, so the checks do not lean on the unit's own sum
    logic [8:0] chk_adc_sum;
    logic [4:0] chk_hc_sum;

    assign chk_adc_sum = {1'b0, acc_r} + {1'b0, operand} + {8'h00, flags_r[ASO_FLG_C]};
    assign chk_hc_sum  = {1'b0, acc_r[3:0]} + {1'b0, operand[3:0]};

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_ptr_flags: assert property (exec_ptr |=> $stable(flags_r) && $stable(acc_r))
        else $error("pointer add changed flags or accumulator");

    chk_ptr_wrap: assert property (exec_ptr && !ptr_sel |=>
        ptr_r[0] == 16'($past(ptr_r[0]) + {{10{$past(iw[5])}}, $past(iw[5:0])}))
        else $error("pointer pair 0 sum wrong");

    chk_ptr_other: assert property (exec_ptr && ptr_sel |=> $stable(ptr_r[0]))
        else $error("pointer select bit ignored");

    chk_andimm_acc: assert property (exec && op == ASO_OP_AND && imm |=>
        acc_r == ($past(acc_r) & $past(iw[7:0]))
        && flags_r[1:0] == $past(flags_r[1:0]))
        else $error("and immediate result or flags wrong");

    chk_addimm_acc: assert property (exec && op == ASO_OP_ADD && imm |=>
        acc_r == 8'($past(acc_r) + $past(iw[7:0])))
        else $error("add immediate sum wrong");

    chk_andreg_flags: assert property (exec && op == ASO_OP_AND && !imm |=>
        $stable(flags_r[ASO_FLG_C]) && $stable(flags_r[ASO_FLG_HC]))
        else $error("and register touched carry flags");

    chk_dest_file: assert property (exec_alu && dest_reg |=> $stable(acc_r))
        else $error("register destination wrote accumulator");

    chk_addreg_dest: assert property (exec && op == ASO_OP_ADD && dest_reg |=>
        dfile_r[$past(fidx)] == 8'($past(acc_r) + $past(operand)))
        else $error("add register result not stored");

    chk_asr_bits: assert property (exec && op == ASO_OP_ASR && !dest_reg |=>
        acc_r == {$past(operand[7]), $past(operand[7:1])}
        && flags_r[ASO_FLG_C] == $past(operand[0]))
        else $error("shift result or carry wrong");

    chk_asr_hc: assert property (exec && op == ASO_OP_ASR |=> $stable(flags_r[ASO_FLG_HC]))
        else $error("shift changed half carry");

    chk_adc_carry: assert property (exec && op == ASO_OP_ADC |=>
        flags_r[ASO_FLG_C] == $past(chk_adc_sum[8]))
        else $error("add with carry carry out wrong");

    chk_zero_flag: assert property (exec_alu |=>
        flags_r[ASO_FLG_Z] == ($past(alu_res) == 8'h00))
        else $error("zero flag does not match result");

    chk_half_carry: assert property (exec && op == ASO_OP_ADD |=>
        flags_r[ASO_FLG_HC] == $past(chk_hc_sum[4]))
        else $error("half carry wrong");

endmodule // aso_core

`default_nettype wire

// File: test_add_and_shift_alu_ops.sv
// Purpose: self-checking bench for the add/and/shift datapath over apb
// Assumes: pready may be held low for a while, so every wait is bounded
// Notes:   expected values are worked out by hand from the operand values
`timescale 1ns/1ns
`default_nettype none

module test_add_and_shift_alu_ops;
    import aso_pkg::*;

    // ****************************************
    // signals and design
    // ****************************************
    logic                  pclk;
    logic                  presetn;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [ASO_AW-1:0]     paddr;
    logic [31:0]           pwdata;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    int                    n_errors;
    int                    checked;
    logic [31:0]           rdv;
    logic                  errv;

    aso_core DUT (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr)
    );

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // ****************************************
    // report and compare
    // ****************************************
    task automatic end_sim();
        $display("checked %0d, n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: read %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_err(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: error response %b, expected %b", $time, got, exp);
        end
    endtask

    // ****************************************
    // apb master
    // ****************************************
    // signals move only right after a rising edge; released after pready
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            n_errors++;
            $display("wrong value at %0t: no ready", $time);
            end_sim();
        end else begin
            rd = prdata;
            err = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        xfer(1'b1, a, d, rd, err);
        cmp_err(err, 1'b0);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic        err;
        xfer(1'b0, a, 32'h0, rd, err);
        cmp_err(err, 1'b0);
        cmp_val(rd, exp);
    endtask

    task automatic exec(input logic [13:0] w);
        wr(ASO_ADDR_INSTR, {18'h0, w});
    endtask

    // accumulator and flags {zero, half carry, carry} in one call
    task automatic chk2(input logic [7:0] acc, input logic [2:0] flg);
        rd_chk(ASO_ADDR_ACC, {24'h0, acc});
        rd_chk(ASO_ADDR_FLAGS, {29'h0, flg});
    endtask

    function automatic logic [11:0] dreg(input int i);
        return ASO_ADDR_DATA_LO + 12'(i * 4);
    endfunction

    // ****************************************
    // sequence
    // ****************************************
    initial begin
        n_errors = 0;
        checked  = 0;
        presetn  = 1'b0;
        psel     = 1'b0;
        penable  = 1'b0;
        pwrite   = 1'b0;
        paddr    = '0;
        pwdata   = 32'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        chk2(8'h00, 3'h0);
        rd_chk(ASO_ADDR_PTR0, 32'h0);
        rd_chk(ASO_ADDR_DATA_HI, 32'h0);
        // add immediate: all three flags set, then all cleared
        wr(ASO_ADDR_ACC, 32'h8f);
        exec(14'h3e71);
        chk2(8'h00, 3'h7);
        exec(14'h3e7f);
        chk2(8'h7f, 3'h0);
        // and immediate: carry and half carry must survive
        wr(ASO_ADDR_FLAGS, 32'h3);
        wr(ASO_ADDR_ACC, 32'hf0);
        exec(14'h390f);
        chk2(8'h00, 3'h7);
        wr(ASO_ADDR_ACC, 32'hff);
        exec(14'h39a5);
        chk2(8'ha5, 3'h3);
        // and register, both destinations
        wr(dreg(5), 32'h3c);
        wr(ASO_ADDR_ACC, 32'h0f);
        wr(ASO_ADDR_FLAGS, 32'h0);
        exec(14'h0585);
        rd_chk(dreg(5), 32'h0c);
        chk2(8'h0f, 3'h0);
        wr(ASO_ADDR_ACC, 32'hf0);
        exec(14'h0505);
        chk2(8'h00, 3'h4);
        rd_chk(dreg(5), 32'h0c);
        // add register at the top index
        wr(ASO_ADDR_DATA_HI, 32'h19);
        wr(ASO_ADDR_ACC, 32'h28);
        exec(14'h07ff);
        rd_chk(ASO_ADDR_DATA_HI, 32'h41);
        chk2(8'h28, 3'h2);
        exec(14'h077f);
        chk2(8'h69, 3'h0);
        // add with carry in
        wr(ASO_ADDR_FLAGS, 32'h1);
        wr(ASO_ADDR_ACC, 32'hff);
        wr(dreg(0), 32'h00);
        exec(14'h3d00);
        chk2(8'h00, 3'h7);
        wr(dreg(0), 32'h10);
        wr(ASO_ADDR_ACC, 32'h20);
        exec(14'h3d80);
        rd_chk(dreg(0), 32'h31);
        chk2(8'h20, 3'h0);
        // arithmetic shift right, sign kept, half carry untouched
        wr(ASO_ADDR_FLAGS, 32'h2);
        wr(dreg(3), 32'h81);
        exec(14'h3703);
        chk2(8'hc0, 3'h3);
        rd_chk(dreg(3), 32'h81);
        wr(ASO_ADDR_FLAGS, 32'h0);
        wr(dreg(3), 32'h01);
        exec(14'h3783);
        rd_chk(dreg(3), 32'h00);
        chk2(8'hc0, 3'h5);
        // pointer add: wrap both ways, flags untouched
        wr(ASO_ADDR_PTR0, 32'hffff);
        exec(14'h3101);
        rd_chk(ASO_ADDR_PTR0, 32'h0000);
        wr(ASO_ADDR_PTR1, 32'h0010);
        exec(14'h3160);
        rd_chk(ASO_ADDR_PTR1, 32'hfff0);
        exec(14'h311f);
        rd_chk(ASO_ADDR_PTR0, 32'h001f);
        rd_chk(ASO_ADDR_PTR1, 32'hfff0);
        chk2(8'hc0, 3'h5);
        // refused accesses leave state alone
        xfer(1'b0, 12'h100, 32'h0, rdv, errv);
        cmp_err(errv, 1'b1);
        cmp_val(rdv, 32'h0);
        xfer(1'b0, 12'h005, 32'h0, rdv, errv);
        cmp_err(errv, 1'b1);
        xfer(1'b1, ASO_ADDR_INSTR, 32'h0, rdv, errv);
        cmp_err(errv, 1'b1);
        rd_chk(ASO_ADDR_INSTR, 32'h311f);
        chk2(8'hc0, 3'h5);
        end_sim();
    end

endmodule // test_add_and_shift_alu_ops

`default_nettype wire
